// [design/tsf_map.svh]
// register offsets, field positions, reset values and timing counts of the transmit status flag block
`ifndef TSF_MAP_SVH
`define TSF_MAP_SVH

// ********************************
// register map (byte addresses)
// ********************************
`define TSF_ADR_W         8
`define TSF_REG_CTRL      8'h00
`define TSF_REG_STATUS    8'h04
`define TSF_REG_LASTWORD  8'h08

// ********************************
// control register fields
// ********************************
`define TSF_CTRL_LBK      0
`define TSF_CTRL_FCSI     13
`define TSF_CTRL_LWSEL    14
`define TSF_CTRL_RST      3'h0

// ********************************
// status fields and reset values
// ********************************
`define TSF_FLAGS_W       11
`define TSF_FLAGS_RST     11'h101
`define TSF_STAT_OVR      16
`define TSF_COLL_W        5
`define TSF_EXC_LIMIT     5'h10
`define TSF_WORD_W        16

// ********************************
// timing
// ********************************
`define TSF_CLK_NS        20
`define TSF_SLOT_NS       51200
`define TSF_SLOT_CYC      ((`TSF_SLOT_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS)
`define TSF_TMR_W         12

`endif

// [design/tsf_pkg.sv]
// types shared by the transmit status flag modules
package tsf_pkg;
`include "tsf_map.svh"

   typedef struct packed {
      logic excess_deferral_flag;
      logic def;
      logic no_carrier_flag;
      logic carrier_lost_flag;
      logic excess_collision_flag;
      logic owc;
      logic rsv4;
      logic monitored_bad_flag;
      logic fu;
      logic byte_count_mismatch_flag;
      logic ptx;
   } tsf_flags_t;

   typedef enum logic [1:0] {
      TSF_IDLE    = 2'b00,
      TSF_TX      = 2'b01,
      TSF_BACKOFF = 2'b10,
      TSF_WB      = 2'b11
   } tsf_phase_t;

endpackage : tsf_pkg

// [design/tsf_link_if.sv]
// signals between the flag logic, its slot timer and its frame monitor
interface tsf_link_if;
   logic tmr_start_pre;
   logic tmr_start_sfd;
   logic tmr_stop;
   logic tmr_sel;
   logic tmr_late;
   logic mon_arm;
   logic mon_inhibit;
   logic mon_done;
   logic mon_crc_bad;
   logic mon_align_err;
   logic mon_sa_miss;
   logic mon_overrun;
   logic mon_bad;
   logic mon_ovr;

   modport core (output tmr_start_pre, tmr_start_sfd, tmr_stop, tmr_sel, mon_arm, mon_inhibit,
                 mon_done, mon_crc_bad, mon_align_err, mon_sa_miss, mon_overrun,
                 input tmr_late, mon_bad, mon_ovr);
   modport timer (input tmr_start_pre, tmr_start_sfd, tmr_stop, tmr_sel, output tmr_late);
   modport monitor (input mon_arm, mon_inhibit, mon_done, mon_crc_bad, mon_align_err, mon_sa_miss,
                    mon_overrun, output mon_bad, mon_ovr);
endinterface : tsf_link_if

// [design/tsf_slot_timer.sv]
// out-of-window collision timer: one slot time from preamble or from frame delimiter
module tsf_slot_timer
   import tsf_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rstn,
   tsf_link_if.timer   lnk
);
   typedef struct packed {
      logic                  run;
      logic [`TSF_TMR_W-1:0] cnt;
      logic                  late;
   } tsf_tmr_t;

   localparam logic [`TSF_TMR_W-1:0] SLOT = `TSF_TMR_W'(`TSF_SLOT_CYC);

   tsf_tmr_t s_r;
   tsf_tmr_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (s_r.run) begin
         if (s_r.cnt == SLOT) begin
            s_nxt.late = 1'b1;
            s_nxt.run  = 1'b0;
         end else begin
            s_nxt.cnt = s_r.cnt + `TSF_TMR_W'(1);
         end
      end
      // select picks which event opens the window
      if ((lnk.tmr_start_pre && lnk.tmr_sel) || (lnk.tmr_start_sfd && !lnk.tmr_sel)) begin
         s_nxt.run  = 1'b1;
         s_nxt.cnt  = '0;
         s_nxt.late = 1'b0;
      end
      if (lnk.tmr_stop || (lnk.tmr_start_pre && !lnk.tmr_sel)) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign lnk.tmr_late = s_r.late;

   slot_expiry_a: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.run && s_r.cnt == SLOT && !lnk.tmr_stop && !lnk.tmr_start_pre && !lnk.tmr_start_sfd)
         |=> lnk.tmr_late) else $error("slot timer did not expire at one slot time");
endmodule : tsf_slot_timer

// [design/tsf_frame_monitor.sv]
// receive-side check of the looped transmitted frame
module tsf_frame_monitor
   import tsf_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rstn,
   tsf_link_if.monitor lnk
);
   typedef struct packed {
      logic inhibit;
      logic bad;
      logic ovr;
   } tsf_mon_t;

   tsf_mon_t s_r;
   tsf_mon_t s_nxt;

   always_comb begin
      s_nxt     = s_r;
      s_nxt.bad = 1'b0;
      if (lnk.mon_arm) begin
         s_nxt.inhibit = lnk.mon_inhibit;
         s_nxt.ovr     = 1'b0;
      end
      // overrun marks the verdict as meaningless; kept for software
      if (lnk.mon_overrun) begin
         s_nxt.ovr = 1'b1;
      end
      // checker listens whatever the transmit state is
      if (lnk.mon_done) begin
         s_nxt.bad = !s_r.inhibit && (lnk.mon_crc_bad || lnk.mon_align_err || lnk.mon_sa_miss);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign lnk.mon_bad = s_r.bad;
   assign lnk.mon_ovr = s_r.ovr;

   inhibit_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      lnk.mon_bad |-> !s_r.inhibit) else $error("monitored bad raised with fcs inhibited");
endmodule : tsf_frame_monitor

// [design/tsf_flags.sv]
// transmit status flag logic with wishbone registers and descriptor status write-back
//
// The Wishbone register port and the register offsets are this design's own decisions.
module tsf_flags
   import tsf_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic [`TSF_ADR_W-1:0]  wb_adr_i,
   input  wire logic [31:0]            wb_dat_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic                   wb_we_i,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   output logic                        wb_ack_o,
   output logic [31:0]                 wb_dat_o,
   input  wire logic                   attempt_start,
   input  wire logic                   new_packet,
   input  wire logic                   sfd_sent,
   input  wire logic                   last_byte,
   input  wire logic                   collision,
   input  wire logic                   crs,
   input  wire logic                   rx_activity,
   input  wire logic                   deferred,
   input  wire logic                   excess_deferral,
   input  wire logic                   fifo_underrun,
   input  wire logic                   byte_count_mismatch,
   input  wire logic                   mon_done,
   input  wire logic                   mon_crc_bad,
   input  wire logic                   mon_align_err,
   input  wire logic                   mon_sa_miss,
   input  wire logic                   rx_overrun,
   output logic                        tx_abort,
   output logic                        tx_backoff,
   output logic                        desc_status_valid,
   output logic [`TSF_WORD_W-1:0]      desc_status_word,
   input  wire logic                   desc_status_done
);
   // ********************************
   // state
   // ********************************
   typedef struct packed {
      tsf_phase_t            phase;
      tsf_flags_t            flags;
      logic [`TSF_COLL_W-1:0] coll;
      logic                  first;
      logic                  in_frame;
      logic                  abort;
      logic                  backoff;
      logic                  ctl_lbk;
      logic                  ctl_fcsi;
      logic                  ctl_lwsel;
      logic                  cfg_lbk;
      logic                  cfg_fcsi;
      logic                  cfg_lwsel;
      logic [`TSF_WORD_W-1:0] word;
      logic                  ack;
      logic [31:0]           rdat;
   } tsf_state_t;

   tsf_state_t s_r;
   tsf_state_t s_nxt;
   tsf_link_if lnk ();

   logic                    carrier_seen;
   logic                    wb_req;
   logic [`TSF_COLL_W-1:0]  coll_inc;
   tsf_flags_t              word_flags;

   function automatic logic [31:0] tsf_status_rd(input tsf_state_t s, input logic ovr);
      tsf_status_rd = {15'h0000, ovr, s.coll, s.flags};
   endfunction : tsf_status_rd

   // ********************************
   // submodules
   // ********************************
   tsf_slot_timer u_timer (
      .clk  (clk),
      .rstn (rstn),
      .lnk  (lnk.timer)
   );

   tsf_frame_monitor u_monitor (
      .clk  (clk),
      .rstn (rstn),
      .lnk  (lnk.monitor)
   );

   assign lnk.tmr_start_pre = attempt_start;
   assign lnk.tmr_start_sfd = sfd_sent && (s_r.phase == TSF_TX);
   assign lnk.tmr_stop      = last_byte || collision;
   assign lnk.tmr_sel       = attempt_start && new_packet ? s_r.ctl_lwsel : s_r.cfg_lwsel;
   assign lnk.mon_arm       = attempt_start && new_packet;
   assign lnk.mon_inhibit   = s_r.ctl_fcsi;
   assign lnk.mon_done      = mon_done;
   assign lnk.mon_crc_bad   = mon_crc_bad;
   assign lnk.mon_align_err = mon_align_err;
   assign lnk.mon_sa_miss   = mon_sa_miss;
   assign lnk.mon_overrun   = rx_overrun;

   // loopback has no carrier of its own: receive activity stands in for it
   assign carrier_seen = s_r.cfg_lbk ? rx_activity : crs;
   assign wb_req       = wb_cyc_i && wb_stb_i;
   assign coll_inc     = s_r.coll + `TSF_COLL_W'(1);
   assign word_flags   = s_r.word[`TSF_FLAGS_W-1:0];

   // ********************************
   // next state
   // ********************************
   always_comb begin
      s_nxt         = s_r;
      s_nxt.abort   = 1'b0;
      s_nxt.backoff = 1'b0;

      // bus slave: ack one cycle after the request, write lands on the acked edge
      s_nxt.ack = wb_req && !s_r.ack;
      if (wb_req && !s_r.ack) begin
         unique case (wb_adr_i)
            `TSF_REG_CTRL: begin
               s_nxt.rdat = 32'h0;
               s_nxt.rdat[`TSF_CTRL_LBK]   = s_r.ctl_lbk;
               s_nxt.rdat[`TSF_CTRL_FCSI]  = s_r.ctl_fcsi;
               s_nxt.rdat[`TSF_CTRL_LWSEL] = s_r.ctl_lwsel;
            end
            `TSF_REG_STATUS:   s_nxt.rdat = tsf_status_rd(s_r, lnk.mon_ovr);
            `TSF_REG_LASTWORD: s_nxt.rdat = {16'h0000, s_r.word};
            default:           s_nxt.rdat = 32'h0;
         endcase
      end
      if (wb_req && s_r.ack && wb_we_i && wb_adr_i == `TSF_REG_CTRL) begin
         if (wb_sel_i[0]) begin
            s_nxt.ctl_lbk = wb_dat_i[`TSF_CTRL_LBK];
         end
         if (wb_sel_i[1]) begin
            s_nxt.ctl_fcsi  = wb_dat_i[`TSF_CTRL_FCSI];
            s_nxt.ctl_lwsel = wb_dat_i[`TSF_CTRL_LWSEL];
         end
      end

      // clears come first so that a same-cycle event wins
      if (s_r.phase == TSF_WB && desc_status_done) begin
         s_nxt.flags.def = 1'b0;
         s_nxt.flags.owc = 1'b0;
         s_nxt.first     = 1'b1;
         s_nxt.phase     = TSF_IDLE;
      end

      if (attempt_start) begin
         if (new_packet) begin
            s_nxt.flags.excess_deferral_flag  = 1'b0;
            s_nxt.flags.carrier_lost_flag = 1'b0;
            s_nxt.flags.excess_collision_flag  = 1'b0;
            s_nxt.flags.byte_count_mismatch_flag  = 1'b0;
            s_nxt.flags.ptx  = 1'b0;
            s_nxt.flags.fu   = 1'b0;
            s_nxt.flags.monitored_bad_flag  = 1'b0;
            s_nxt.coll       = '0;
            s_nxt.cfg_lbk    = s_r.ctl_lbk;
            s_nxt.cfg_fcsi   = s_r.ctl_fcsi;
            s_nxt.cfg_lwsel  = s_r.ctl_lwsel;
         end
         s_nxt.flags.no_carrier_flag = 1'b1;
         s_nxt.in_frame   = 1'b0;
         s_nxt.phase      = TSF_TX;
      end else if (s_r.phase == TSF_TX) begin
         // no_carrier_flag only falls on carrier, so silence leaves it set at the end
         if (carrier_seen) begin
            s_nxt.flags.no_carrier_flag = 1'b0;
         end
         if (sfd_sent) begin
            s_nxt.in_frame = 1'b1;
            if (s_r.cfg_lbk) begin
               s_nxt.flags.carrier_lost_flag = 1'b1;
            end
         end
         if (s_r.in_frame && !crs) begin
            s_nxt.flags.carrier_lost_flag = 1'b1;
         end
         if (collision) begin
            s_nxt.coll     = coll_inc;
            s_nxt.first    = 1'b0;
            s_nxt.in_frame = 1'b0;
            if (lnk.tmr_late) begin
               s_nxt.flags.owc = 1'b1;
            end
            if (coll_inc == `TSF_EXC_LIMIT) begin
               s_nxt.flags.excess_collision_flag = 1'b1;
               s_nxt.abort     = 1'b1;
               s_nxt.phase     = TSF_WB;
               // an aborted attempt that never saw carrier reports both flags too
               if (s_nxt.flags.no_carrier_flag) begin
                  s_nxt.flags.carrier_lost_flag = 1'b1;
               end
            end else begin
               // late or not, the retry path is the same
               s_nxt.backoff = 1'b1;
               s_nxt.phase   = TSF_BACKOFF;
            end
         end else if (last_byte) begin
            // carrier trouble never aborts; the frame always runs to its last byte
            if (s_nxt.flags.no_carrier_flag) begin
               s_nxt.flags.carrier_lost_flag = 1'b1;
            end
            s_nxt.in_frame  = 1'b0;
            s_nxt.flags.ptx = !s_nxt.flags.fu && !s_nxt.flags.excess_collision_flag;
            s_nxt.phase     = TSF_WB;
         end
      end

      if (deferred && s_r.first) begin
         s_nxt.flags.def = 1'b1;
      end
      if (excess_deferral) begin
         s_nxt.flags.excess_deferral_flag = 1'b1;
      end
      if (fifo_underrun) begin
         s_nxt.flags.fu = 1'b1;
      end
      if (byte_count_mismatch) begin
         s_nxt.flags.byte_count_mismatch_flag = 1'b1;
      end
      if (lnk.mon_bad) begin
         s_nxt.flags.monitored_bad_flag = 1'b1;
      end

      // snapshot taken once, so late monitor results do not tear the word
      if (s_nxt.phase == TSF_WB && s_r.phase != TSF_WB) begin
         s_nxt.word = {s_nxt.coll, s_nxt.flags};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r       <= '0;
         s_r.phase <= TSF_IDLE;
         s_r.flags <= `TSF_FLAGS_RST;
         s_r.first <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign wb_ack_o          = s_r.ack;
   assign wb_dat_o          = s_r.rdat;
   assign tx_abort          = s_r.abort;
   assign tx_backoff        = s_r.backoff;
   assign desc_status_valid = (s_r.phase == TSF_WB);
   assign desc_status_word  = s_r.word;

   // ********************************
   // checks
   // ********************************
   sequence tsf_late_hit;
      (s_r.phase == TSF_TX) && lnk.tmr_late && collision && !attempt_start && coll_inc != `TSF_EXC_LIMIT;
   endsequence

   sequence tsf_retry;
      tx_backoff && s_r.flags.owc && !tx_abort;
   endsequence

   no_carrier_flag_start_set_a: assert property (@(posedge clk) disable iff (!rstn)
      attempt_start |=> s_r.flags.no_carrier_flag && s_r.phase == TSF_TX)
      else $error("no-carrier not set at transmission start");

   no_carrier_flag_crs_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.phase == TSF_TX && !attempt_start && carrier_seen) |=> !s_r.flags.no_carrier_flag)
      else $error("no-carrier not cleared on carrier");

   lbk_no_carrier_flag_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.cfg_lbk && s_r.phase == TSF_TX && !rx_activity && !attempt_start) |=>
         s_r.flags.no_carrier_flag == $past(s_r.flags.no_carrier_flag))
      else $error("no-carrier changed in loopback without receive activity");

   carrier_lost_flag_loss_a: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.phase == TSF_TX && s_r.in_frame && !crs && !attempt_start) |=> s_r.flags.carrier_lost_flag)
      else $error("carrier loss inside frame not recorded");

   both_carrier_a: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.phase == TSF_WB && word_flags.no_carrier_flag) |-> word_flags.carrier_lost_flag)
      else $error("no-carrier written without carrier-lost");

   abort_cause_a: assert property (@(posedge clk) disable iff (!rstn)
      tx_abort |-> s_r.flags.excess_collision_flag && s_r.coll == `TSF_EXC_LIMIT)
      else $error("abort without excessive collisions");

   exc_abort_a: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.phase == TSF_TX && collision && !attempt_start && coll_inc == `TSF_EXC_LIMIT) |=>
         tx_abort && s_r.flags.excess_collision_flag ##1 !tx_abort)
      else $error("excessive collisions did not abort");

   owc_retry_a: assert property (@(posedge clk) disable iff (!rstn)
      tsf_late_hit |=> tsf_retry)
      else $error("late collision did not back off");

   owc_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      (desc_status_valid && desc_status_done && !collision) |=> !s_r.flags.owc && !desc_status_valid)
      else $error("out-of-window flag not cleared after write-back");

   start_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      (attempt_start && new_packet && !excess_deferral && !byte_count_mismatch) |=>
         !s_r.flags.carrier_lost_flag && !s_r.flags.excess_collision_flag && !s_r.flags.excess_deferral_flag && !s_r.flags.byte_count_mismatch_flag && s_r.flags.no_carrier_flag)
      else $error("packet start did not reset flags");

   wb_word_a: assert property (@(posedge clk) disable iff (!rstn)
      (s_r.phase == TSF_TX && last_byte && !collision && !attempt_start) |=>
         desc_status_valid && desc_status_word[`TSF_FLAGS_W-1:0] == s_r.flags)
      else $error("status word not offered at end of transmission");
endmodule : tsf_flags

// [verification/tsf_wb_path_model.sv]
// descriptor write-back path model: stores each status word after a random delay
module tsf_wb_path_model (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic desc_status_valid,
   output logic      desc_status_done
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [1:0] st_r;
   logic [2:0] cnt_r;

   // ********************************
   // handshake
   // ********************************
   // waits for valid to fall before taking the next word, so one word is never stored twice
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r             <= 2'h0;
         cnt_r            <= 3'h0;
         desc_status_done <= 1'b0;
      end else begin
         desc_status_done <= 1'b0;
         case (st_r)
            2'h0: if (desc_status_valid === 1'b1) begin
               cnt_r <= 3'($urandom_range(0, 5));
               st_r  <= 2'h1;
            end
            2'h1: if (cnt_r == 3'h0) begin
               desc_status_done <= 1'b1; // word now in memory
               st_r             <= 2'h2;
            end else begin
               cnt_r <= cnt_r - 3'h1;
            end
            default: if (desc_status_valid === 1'b0) begin
               st_r <= 2'h0;
            end
         endcase
      end
   end
endmodule : tsf_wb_path_model

// [verification/tsf_flags_bench.sv]
// self-checking bench of the transmit status flag logic
`include "tsf_map.svh"
module tsf_flags_bench
   import tsf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic                  clk, rstn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [`TSF_ADR_W-1:0] wb_adr_i;
   logic [31:0]           wb_dat_i, wb_dat_o;
   logic [3:0]            wb_sel_i;
   logic [7:0]            evt; // start, new, sfd, last, coll, defer, mon_done, overrun
   logic [2:0]            aux; // excess deferral, underrun, count mismatch
   logic                  crs, rx_activity, mon_crc_bad, mon_align_err, mon_sa_miss;
   logic                  tx_abort, tx_backoff, desc_status_valid, desc_status_done, vld_prev;
   logic [15:0]           desc_status_word;
   logic [15:0]           exp_q[$];
   int                    fails, checked;

   tsf_flags dut (.clk(clk), .rstn(rstn), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .attempt_start(evt[7]), .new_packet(evt[6]), .sfd_sent(evt[5]), .last_byte(evt[4]),
      .collision(evt[3]), .crs(crs), .rx_activity(rx_activity), .deferred(evt[2]),
      .excess_deferral(aux[2]), .fifo_underrun(aux[1]), .byte_count_mismatch(aux[0]), .mon_done(evt[1]),
      .mon_crc_bad(mon_crc_bad), .mon_align_err(mon_align_err), .mon_sa_miss(mon_sa_miss),
      .rx_overrun(evt[0]), .tx_abort(tx_abort), .tx_backoff(tx_backoff),
      .desc_status_valid(desc_status_valid), .desc_status_word(desc_status_word),
      .desc_status_done(desc_status_done));

   tsf_wb_path_model far (.clk(clk), .rstn(rstn), .desc_status_valid(desc_status_valid),
      .desc_status_done(desc_status_done));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ********************************
   // checking and closing
   // ********************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic give_verdict;
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   // each new status word is matched against the oldest noted expectation
   always @(posedge clk) begin
      if (desc_status_valid === 1'b1 && vld_prev !== 1'b1) begin
         chk("status word", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, desc_status_word);
      end
      vld_prev <= desc_status_valid;
   end

   // ********************************
   // drivers
   // ********************************
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] rd);
      int n;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         fails++;
         give_verdict();
      end
   endtask : wb

   task automatic pulse(input logic [7:0] v, input int gap);
      @(posedge clk);
      evt <= v;
      @(posedge clk);
      evt <= 8'h00;
      repeat (gap) @(posedge clk);
   endtask : pulse

   task automatic wait_wb;
      int   n;
      logic seen;
      seen = 1'b0;
      for (n = 0; n < 100 && !(seen && desc_status_valid === 1'b0); n++) begin
         @(posedge clk);
         seen = seen | (desc_status_valid === 1'b1);
      end
      if (!seen || desc_status_valid !== 1'b0) begin
         fails++;
         give_verdict();
      end
   endtask : wait_wb

   task automatic pkt(input logic dfr, input logic c, input logic [15:0] w);
      exp_q.push_back(w);
      pulse(8'hc0, 0);
      crs <= c;
      if (dfr) pulse(8'h04, 0);
      pulse(8'h00, 2);
      pulse(8'h20, 10);
      pulse(8'h10, 0);
      wait_wb();
   endtask : pkt

   // ********************************
   // scenarios
   // ********************************
   initial begin
      logic [31:0] rd;
      logic [2:0]  err;
      {rstn, evt, aux, crs, rx_activity, mon_crc_bad, mon_align_err, mon_sa_miss} = '0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
      fails = 0;
      checked = 0;
      void'($urandom(32'h1b6a));
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      wb(1'b0, `TSF_REG_STATUS, 32'h0, rd);
      chk("status after reset", 32'h101, rd);
      wb(1'b1, `TSF_REG_STATUS, 32'hffff, rd);
      wb(1'b0, `TSF_REG_STATUS, 32'h0, rd);
      chk("status read only", 32'h101, rd);
      wb(1'b0, 8'h40, 32'h0, rd);
      chk("unmapped read", 32'h0, rd);
      pkt(1'b1, 1'b0, 16'h0381);
      wb(1'b0, `TSF_REG_LASTWORD, 32'h0, rd);
      chk("last word", 32'h381, rd);
      pkt(1'b0, 1'b1, 16'h0001);
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, `TSF_REG_CTRL, 32'h1, rd);
         rx_activity <= i[0];
         pkt(1'b0, 1'b1, i ? 16'h0081 : 16'h0181);
      end
      rx_activity <= 1'b0;
      // collision 2500 cycles after the delimiter: late only when timed from preamble
      for (int s = 1; s >= 0; s--) begin
         wb(1'b1, `TSF_REG_CTRL, 32'(s) << 14, rd);
         exp_q.push_back(16'h0801 | (16'(s) << 5));
         pulse(8'hc0, 100);
         pulse(8'h20, 2500);
         pulse(8'h08, 0);
         @(negedge clk);
         chk("late collision outcome", 32'h1, {tx_abort, tx_backoff});
         pulse(8'h80, 2);
         pulse(8'h20, 5);
         pulse(8'h10, 0);
         wait_wb();
      end
      wb(1'b1, `TSF_REG_CTRL, 32'h0, rd);
      exp_q.push_back(16'h8040);
      for (int i = 1; i <= 16; i++) begin
         pulse({1'b1, i == 1, 6'h00}, 3);
         pulse(8'h08, 0);
         @(negedge clk);
         chk("collision outcome", {30'h0, i == 16, i != 16}, {tx_abort, tx_backoff});
      end
      wait_wb();
      // exd, fu and bcm raised mid-packet; the packet after must start with them clear
      exp_q.push_back(16'h0406);
      pulse(8'hc0, 2);
      aux <= 3'h7;
      @(posedge clk);
      aux <= 3'h0;
      pulse(8'h20, 3);
      pulse(8'h10, 0);
      wait_wb();
      pkt(1'b0, 1'b1, 16'h0001);
      // monitor verdict lands after the word snapshot, so it is read from the status register
      for (int f = 0; f < 2; f++) begin
         wb(1'b1, `TSF_REG_CTRL, 32'(f) << 13, rd);
         wb(1'b0, `TSF_REG_CTRL, 32'h0, rd);
         chk("control readback", 32'(f) << 13, rd);
         pkt(1'b0, 1'b1, 16'h0001);
         err = 3'($urandom_range(1, 7));
         {mon_crc_bad, mon_align_err, mon_sa_miss} <= err;
         pulse(8'h03, 2);
         wb(1'b0, `TSF_REG_STATUS, 32'h0, rd);
         chk("monitor verdict", f ? 32'h10000 : 32'h10008, rd & 32'h10008);
      end
      give_verdict();
   end
endmodule : tsf_flags_bench
